/* design/tam_top.sv */
// Purpose: Target address slot registers and address match for an I2C port
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, clk 200 MHz
// Notes: Unmapped addresses ack with zero data and drop writes
// Contract
// - Length bit selects 7 or 10-bit compare
// - Disable bit removes slot from matching
// - Slot 0 resets enabled, fields zero
// - Slots 1, 2 reset disabled, fields zero
// - 7-bit mode compares field bits 6:0
// - 10-bit mode: nine address bits, r/w LSB
// - Slots count only when controller role is 0
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module tam_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tam_pkg::TAM_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ctrl_role,
	input wire logic addr_valid,
	input wire logic addr_10b,
	input wire logic [9:0] addr_rx,
	output logic addr_ack,
	output logic addr_nack
);
	import tam_pkg::*;
	tam_slot_t slot_ff [TAM_NUM_SLOTS];
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic req;
	logic [TAM_NUM_SLOTS-1:0] sel_slot;
	logic [31:0] rd_mux;
	tam_match_if mif ();

	////////////////////////////////////////////////////////////////////
	// Decode
	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign sel_slot[0] = wb_adr_i == TAM_OFS_SLOT0;
	assign sel_slot[1] = wb_adr_i == TAM_OFS_SLOT1;
	assign sel_slot[2] = wb_adr_i == TAM_OFS_SLOT2;

	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < TAM_NUM_SLOTS; i++) begin
			if (sel_slot[i]) begin
				rd_mux[TAM_ADDR_LSB +: TAM_ADDR_W] = slot_ff[i].addr;
				rd_mux[TAM_DIS_BIT] = slot_ff[i].dis;
				rd_mux[TAM_LEN_BIT] = slot_ff[i].len10;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slot registers; lane 0 holds addr[7:0], lane 1 the rest
	genvar g;
	generate
		for (g = 0; g < TAM_NUM_SLOTS; g++) begin : g_reg
			logic wr;
			assign wr = req && wb_we_i && sel_slot[g];
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					slot_ff[g].addr <= TAM_ADDR_RST;
					slot_ff[g].len10 <= TAM_LEN_RST;
					slot_ff[g].dis <= (g == 0) ? TAM_DIS0_RST : TAM_DISN_RST;
				end else if (wr) begin
					if (wb_sel_i[0]) begin
						slot_ff[g].addr[7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						slot_ff[g].addr[9:8] <= wb_dat_i[9:8];
						slot_ff[g].dis <= wb_dat_i[TAM_DIS_BIT];
						slot_ff[g].len10 <= wb_dat_i[TAM_LEN_BIT];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Bus answer: ack one cycle after request, dropped the next
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= req;
			rdat_ff <= req ? rd_mux : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	////////////////////////////////////////////////////////////////////
	// Matcher
	assign mif.slot = slot_ff;
	assign mif.ctrl_role = ctrl_role;
	assign mif.addr_valid = addr_valid;
	assign mif.addr_10b = addr_10b;
	assign mif.addr_rx = addr_rx;

	tam_match u_match (
		.clk(clk),
		.rst(rst),
		.mif(mif)
	);

	assign addr_ack = mif.hit;
	assign addr_nack = mif.miss;
endmodule

/* design/tam_pkg.sv */
// Purpose: Shared constants for the target address match block
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses
// Notes: Three address slots, each in one aligned word
package tam_pkg;
	localparam int TAM_NUM_SLOTS = 3;
	localparam int TAM_ADR_W = 8;
	localparam logic [7:0] TAM_OFS_SLOT0 = 8'h4c;
	localparam logic [7:0] TAM_OFS_SLOT1 = 8'h50;
	localparam logic [7:0] TAM_OFS_SLOT2 = 8'h54;
	localparam int TAM_ADDR_LSB = 0;
	localparam int TAM_ADDR_W = 10;
	localparam int TAM_DIS_BIT = 10;
	localparam int TAM_LEN_BIT = 15;
	localparam logic [9:0] TAM_ADDR_RST = 10'h000;
	localparam logic TAM_LEN_RST = 1'b0;
	localparam logic TAM_DIS0_RST = 1'b0;
	localparam logic TAM_DISN_RST = 1'b1;
	typedef struct packed {
		logic len10;
		logic dis;
		logic [9:0] addr;
	} tam_slot_t;
endpackage

/* design/tam_match_if.sv */
// Purpose: Carries slot setup and address phase between top and matcher
// Assumes: Same clock on both sides
// Notes: None
`timescale 1ns/1ps
interface tam_match_if;
	import tam_pkg::*;
	tam_slot_t slot [TAM_NUM_SLOTS];
	logic ctrl_role;
	logic addr_valid;
	logic addr_10b;
	logic [9:0] addr_rx;
	logic hit;
	logic miss;
	modport cfg (output slot, ctrl_role, addr_valid, addr_10b, addr_rx, input hit, miss);
	modport match (input slot, ctrl_role, addr_valid, addr_10b, addr_rx, output hit, miss);
endinterface

/* design/tam_match.sv */
// Purpose: Compares a received address against enabled slots
// Assumes: Address phase strobes come from logic on clk
// Notes: Result is one registered pulse, one cycle after the strobe
`timescale 1ns/1ps
module tam_match (
	input wire logic clk,
	input wire logic rst,
	tam_match_if.match mif
);
	import tam_pkg::*;
	logic [TAM_NUM_SLOTS-1:0] slot_eq;
	logic any_eq;
	logic hit_ff;
	logic miss_ff;
	logic nxt_hit;
	logic nxt_miss;

	////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < TAM_NUM_SLOTS; g++) begin : g_slot
			logic eq7;
			logic eq10;
			assign eq7 = mif.slot[g].addr[6:0] == mif.addr_rx[6:0];
			assign eq10 = mif.slot[g].addr[9:1] == mif.addr_rx[9:1];
			assign slot_eq[g] = !mif.slot[g].dis && (mif.slot[g].len10 == mif.addr_10b) &&
				(mif.slot[g].len10 ? eq10 : eq7);
		end
	endgenerate

	assign any_eq = |slot_eq;
	assign nxt_hit = mif.addr_valid && !mif.ctrl_role && any_eq;
	assign nxt_miss = mif.addr_valid && !mif.ctrl_role && !any_eq;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hit_ff <= 1'b0;
			miss_ff <= 1'b0;
		end else begin
			hit_ff <= nxt_hit;
			miss_ff <= nxt_miss;
		end
	end

	assign mif.hit = hit_ff;
	assign mif.miss = miss_ff;
endmodule

/* sim/tam_top_props.sv */
// Purpose: Port checks for tam_top
// Assumes: Bound from the bench
// Notes: fresh_ff stays high until the first write
`timescale 1ns/1ps
module tam_top_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic ctrl_role,
	input wire logic addr_valid,
	input wire logic addr_10b,
	input wire logic [9:0] addr_rx,
	input wire logic addr_ack,
	input wire logic addr_nack
);
	logic fresh_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fresh_ff <= 1'b1;
		else if (wb_stb_i && wb_we_i)
			fresh_ff <= 1'b0;
	end
	////////////////////////////////////////////////////////////////
	sequence s_tgt; addr_valid && !ctrl_role; endsequence
	sequence s_rd; fresh_ff && wb_ack_o && !wb_we_i; endsequence
	property p_resp; s_tgt |=> addr_ack != addr_nack; endproperty
	a_resp: assert property (p_resp) else $error("no single answer");
	property p_role; addr_valid && ctrl_role |=> !addr_ack && !addr_nack; endproperty
	a_role: assert property (p_role) else $error("answer as controller");
	property p_idle; !addr_valid |=> !(addr_ack || addr_nack); endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_s0; s_tgt ##0 (fresh_ff && !addr_10b && addr_rx[6:0] == 7'h00) |=> addr_ack; endproperty
	a_s0: assert property (p_s0) else $error("slot 0 not on");
	property p_s12; s_tgt ##0 (fresh_ff && !addr_10b && addr_rx[6:0] != 7'h00) |=> addr_nack; endproperty
	a_s12: assert property (p_s12) else $error("slot 1 or 2 on");
	property p_len; s_tgt ##0 (fresh_ff && addr_10b) |=> addr_nack; endproperty
	a_len: assert property (p_len) else $error("length ignored");
	property p_rd12; s_rd ##0 (wb_adr_i == 8'h50 || wb_adr_i == 8'h54) |-> wb_dat_o == 32'h0000_0400; endproperty
	a_rd12: assert property (p_rd12) else $error("slot 1 or 2 reset");
	property p_rd0; s_rd ##0 wb_adr_i == 8'h4c |-> wb_dat_o == 32'h0000_0000; endproperty
	a_rd0: assert property (p_rd0) else $error("slot 0 reset");
endmodule

/* sim/tam_ctl_model.sv */
// Purpose: Bus controller issuing address phases
// Assumes: One phase per call
// Notes: Released lines show the inverse of the last address
`timescale 1ns/1ps
module tam_ctl_model (
	input wire logic clk,
	output logic addr_valid = 1'b0,
	output logic addr_10b = 1'b0,
	output logic [9:0] addr_rx = 10'h000
);
	task send(input logic b, input logic [9:0] a);
		@(posedge clk);
		addr_valid <= 1'b1;
		addr_10b <= b;
		addr_rx <= a;
		@(posedge clk);
		addr_valid <= 1'b0;
		addr_10b <= ~b;
		addr_rx <= ~a;
	endtask
endmodule

/* sim/tam_top_tb.sv */
// Purpose: Self-checking bench for tam_top
// Assumes: 200 MHz clk, async high reset
// Notes: Drivers queue expectations, monitor compares
`timescale 1ns/1ps
module tam_top_tb;
	import tam_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, ctrl_role = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic wb_ack_o, addr_valid, addr_10b, addr_ack, addr_nack;
	logic [9:0] addr_rx, a1, a2;
	logic [31:0] rq[$];
	logic [1:0] mq[$];
	int fail_count = 0, comparisons = 0, seed = 32'h59dc;
	always #2.5 clk = ~clk;
	tam_top DUT (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .ctrl_role, .addr_valid, .addr_10b, .addr_rx, .addr_ack, .addr_nack);
	tam_ctl_model u_ctl (.clk, .addr_valid, .addr_10b, .addr_rx);
	task cmp_rd(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task cmp_m(input logic [1:0] e, input logic [1:0] g);
		cmp_rd({30'h0, e}, {30'h0, g});
	endtask
	task complete_run;
		fail_count += rq.size() + mq.size();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask
	task ph(input logic b, input logic [9:0] a, input logic [1:0] e);
		if (e != 2'b00)
			mq.push_back(e);
		u_ctl.send(b, a);
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (wb_ack_o && !wb_we_i)
			cmp_rd(rq.pop_front(), wb_dat_o);
		if (addr_ack || addr_nack)
			cmp_m(mq.pop_front(), {addr_ack, addr_nack});
	end
	initial begin
		#5000;
		fail_count++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(8'h4c, 32'h0000_0000);
		rd(8'h50, 32'h0000_0400);
		rd(8'h54, 32'h0000_0400);
		rd(8'h10, 32'h0000_0000);
		ph(1'b0, 10'h380, 2'b10);
		ph(1'b0, 10'h005, 2'b01);
		ph(1'b1, 10'h000, 2'b01);
		$display("test reset done");
		a1 = 10'($random(seed)) | 10'h001;
		a2 = 10'($random(seed));
		wb(1'b1, 8'h4c, 32'h0000_0400);
		wb(1'b1, 8'h50, {22'h0, a1});
		wb(1'b1, 8'h54, {16'h0, 1'b1, 5'h0, a2});
		rd(8'h4c, 32'h0000_0400);
		rd(8'h54, {16'h0, 1'b1, 5'h0, a2});
		ph(1'b0, a1 ^ 10'h380, 2'b10);
		ph(1'b0, 10'h000, 2'b01);
		ph(1'b1, a2 ^ 10'h001, 2'b10);
		ph(1'b1, a2 ^ 10'h002, 2'b01);
		$display("test slots done");
		ctrl_role <= 1'b1;
		ph(1'b0, a1, 2'b00);
		ctrl_role <= 1'b0;
		ph(1'b0, a1, 2'b10);
		$display("test role done");
		repeat (3) @(posedge clk);
		complete_run;
	end
endmodule
bind tam_top tam_top_props u_props (.clk, .rst, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .ctrl_role, .addr_valid, .addr_10b, .addr_rx, .addr_ack, .addr_nack);
